// ==== design/sadc_defs.svh ====
// Purpose: Constants for the serial converter interface and conversion control.
// Assumes: Included by bare name; the guard keeps double inclusion harmless.
// Notes:   Counts are sized to the counters they are compared against.
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

// ----------------------------------------------------------------------------
// Widths and sizes
// ----------------------------------------------------------------------------
`define SADC_RES_W       10
`define SADC_CH_W        4
`define SADC_NUM_CH      14
`define SADC_CNT_W       5
`define SADC_IDX_W       4
`define SADC_SYNC_W      3
`define SADC_FIFO_DEPTH  4

// ----------------------------------------------------------------------------
// Shift clock edge counts
// ----------------------------------------------------------------------------
`define SADC_CNT_MAX     5'h1F
`define SADC_CNT_ONE     5'h01
`define SADC_CNT_ZERO    5'h00
`define SADC_ADDR_LAST   5'h03
`define SADC_ADDR_DONE   5'h04
`define SADC_SAMPLE_FALL 5'h04
`define SADC_ZERO_FALL   5'h0A
`define SADC_CONV_FALL   5'h0A

// ----------------------------------------------------------------------------
// Successive approximation
// ----------------------------------------------------------------------------
`define SADC_MSB_IDX     4'h9
`define SADC_LSB_IDX     4'h0
`define SADC_IDX_ONE     4'h1
`define SADC_TRIAL_INIT  10'h200

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SADC_RST_RESULT  10'h000
`define SADC_RST_CHAN    4'h0
`define SADC_RST_SEL     14'h0000
`define SADC_RST_SYNC    3'h7

`endif

// ==== design/sadc_pkg.sv ====
// Purpose: Types shared by the converter control block.
// Assumes: The defs header supplies every width.
// Notes:   State codes are one-hot.
`include "sadc_defs.svh"

package sadc_pkg;

  // --------------------------------------------------------------------------
  // Converter state machine
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    SADC_IDLE   = 4'b0001,
    SADC_SAMPLE = 4'b0010,
    SADC_CONV   = 4'b0100,
    SADC_PUSH   = 4'b1000
  } sadc_state_t;

  // --------------------------------------------------------------------------
  // Complete state of the top module
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [`SADC_SYNC_W-1:0] cs_sy;
    logic [`SADC_SYNC_W-1:0] ck_sy;
    logic [`SADC_SYNC_W-1:0] ad_sy;
    logic                    cs_f;
    logic                    ck_f;
    logic                    ad_f;
    logic                    cs_prev;
    logic                    ck_prev;
    logic [`SADC_CNT_W-1:0]  rise_cnt;
    logic [`SADC_CNT_W-1:0]  fall_cnt;
    logic [`SADC_CH_W-1:0]   addr_sh;
    logic [`SADC_CH_W-1:0]   chan;
    logic [`SADC_NUM_CH-1:0] chan_sel;
    logic [`SADC_RES_W-1:0]  held;
    logic [`SADC_RES_W-1:0]  shf;
    logic [`SADC_RES_W-1:0]  trial;
    logic [`SADC_IDX_W-1:0]  bit_idx;
    logic                    dout_oe;
    logic                    eoc;
    logic                    sample;
    sadc_state_t             state;
  } sadc_regs_t;

endpackage : sadc_pkg

// ==== design/sadc_ctrl.sv ====
// Purpose: Serial interface and conversion control of a 10-bit successive-approximation converter.
// Assumes: Select, shift clock and address come from another clock domain and are sampled here.
// Notes:   Results pass through a small FIFO before the held result register.
`timescale 1ns/1ps
`include "sadc_defs.svh"

// ----------------------------------------------------------------------------
// Result FIFO
// ----------------------------------------------------------------------------
module sadc_fifo #(
  parameter int WIDTH = `SADC_RES_W,
  parameter int DEPTH = `SADC_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  // Pointers wrap by width; the count has one extra bit to tell full from empty.
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 cnt;
  } sadc_fifo_regs_t;

  sadc_fifo_regs_t q;
  sadc_fifo_regs_t d;
  logic            push;
  logic            pop;

  // Show-ahead: the head word stands on out_data while out_valid is high.
  assign in_ready  = (q.cnt != DEPTH[PW:0]);
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rd];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr        = q.wr + PW'(1);
    end
    if (pop) begin
      d.rd = q.rd + PW'(1);
    end
    d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // sadc_fifo

// ----------------------------------------------------------------------------
// Converter control top
// ----------------------------------------------------------------------------
module sadc_ctrl
  import sadc_pkg::*;
(
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst,
  // Serial link pins
  input  wire logic                    cs_n,
  input  wire logic                    shift_clk,
  input  wire logic                    addr_in,
  output logic                         dout_o,
  output logic                         dout_oe,
  output logic                         eoc,
  // Analog front end
  output logic [`SADC_NUM_CH-1:0]      chan_sel,
  output logic                         sample_en,
  output logic [`SADC_RES_W-1:0]       dac_code,
  input  wire logic                    cmp_hi
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // A high level followed by a low one; swapping the arguments finds a rise.
  function automatic logic fell(input logic prev, input logic now);
    fell = prev & ~now;
  endfunction

  function automatic logic [`SADC_SYNC_W-1:0] shift_in(input logic [`SADC_SYNC_W-1:0] sy, input logic pin);
    shift_in = {sy[`SADC_SYNC_W-2:0], pin};
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  sadc_regs_t             q;
  sadc_regs_t             d;
  logic                   active;
  logic                   ck_fall;
  logic                   ck_rise;
  logic                   link_quiet;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic                   fifo_pop;
  logic [`SADC_RES_W-1:0] fifo_out_data;
  // Fall count after this cycle's fall, held at the counter's top.
  logic [`SADC_CNT_W-1:0] nf;

  // A new result may enter the held register only outside an active shift-out.
  assign link_quiet = q.cs_f | (q.rise_cnt == `SADC_CNT_ZERO) | (q.fall_cnt >= `SADC_ZERO_FALL);
  assign fifo_pop   = fifo_out_valid & link_quiet;

  // Finished results wait here for a quiet link; a full FIFO holds the converter in SADC_PUSH.
  sadc_fifo #(
    .WIDTH (`SADC_RES_W),
    .DEPTH (`SADC_FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (q.state == SADC_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   (q.trial),
    .out_valid (fifo_out_valid),
    .out_ready (link_quiet),
    .out_data  (fifo_out_data)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    d       = q;
    nf      = q.fall_cnt;
    active  = ~q.cs_f;
    // Edges count only while select is active.
    ck_fall = active & fell(q.ck_prev, q.ck_f);
    ck_rise = active & fell(q.ck_f, q.ck_prev);

    // Pin synchronisers: a level is taken once the second and third stages agree.
    d.cs_sy = shift_in(q.cs_sy, cs_n);
    d.ck_sy = shift_in(q.ck_sy, shift_clk);
    d.ad_sy = shift_in(q.ad_sy, addr_in);
    if (q.cs_sy[2] == q.cs_sy[1]) begin
      d.cs_f = q.cs_sy[1];
    end
    if (q.ck_sy[2] == q.ck_sy[1]) begin
      d.ck_f = q.ck_sy[1];
    end
    if (q.ad_sy[2] == q.ad_sy[1]) begin
      d.ad_f = q.ad_sy[1];
    end
    d.cs_prev = q.cs_f;
    d.ck_prev = q.ck_f;
    d.dout_oe = active;

    // Select falling restarts the link counters and reloads the MSB.
    if (fell(q.cs_prev, q.cs_f)) begin
      d.rise_cnt = `SADC_CNT_ZERO;
      d.fall_cnt = `SADC_CNT_ZERO;
      d.shf      = q.held;
    end else begin
      // Rises take the address until four bits are in; later rises change nothing.
      if (ck_rise && q.rise_cnt < `SADC_ADDR_DONE) begin
        d.addr_sh  = {q.addr_sh[`SADC_CH_W-2:0], q.ad_f};
        d.rise_cnt = q.rise_cnt + `SADC_CNT_ONE;
        if (q.rise_cnt == `SADC_ADDR_LAST) begin
          d.chan     = {q.addr_sh[`SADC_CH_W-2:0], q.ad_f};
          d.chan_sel = `SADC_RST_SEL;
          if ({q.addr_sh[`SADC_CH_W-2:0], q.ad_f} < `SADC_CH_W'(`SADC_NUM_CH)) begin
            d.chan_sel[{q.addr_sh[`SADC_CH_W-2:0], q.ad_f}] = 1'b1;
          end
        end
      end
      // Falls shift the result out, open sampling on the fourth and start converting on the tenth.
      if (ck_fall) begin
        if (q.fall_cnt != `SADC_CNT_MAX) begin
          nf = q.fall_cnt + `SADC_CNT_ONE;
        end
        d.fall_cnt = nf;
        if (nf >= `SADC_ZERO_FALL) begin
          d.shf = `SADC_RST_RESULT;
        end else begin
          d.shf = {q.shf[`SADC_RES_W-2:0], 1'b0};
        end
        if (nf == `SADC_SAMPLE_FALL && q.state == SADC_IDLE) begin
          d.state  = SADC_SAMPLE;
          d.sample = 1'b1;
        end
        if (nf == `SADC_CONV_FALL && q.state == SADC_SAMPLE) begin
          d.sample  = 1'b0;
          d.eoc     = 1'b0;
          d.state   = SADC_CONV;
          d.trial   = `SADC_TRIAL_INIT;
          d.bit_idx = `SADC_MSB_IDX;
        end
      end
    end

    // Converter state machine on the internal clock.
    case (q.state)
      SADC_IDLE: begin
        // Sampling opens in the same cycle as the step into SADC_SAMPLE.
        d.sample = (d.state == SADC_SAMPLE);
      end
      SADC_SAMPLE: begin
        // The tenth fall moves on to SADC_CONV and so closes the sample window.
        d.sample = (d.state == SADC_SAMPLE);
      end
      SADC_CONV: begin
        // One trial bit per cycle: keep it if the input is at or above the trial code.
        d.trial[q.bit_idx] = cmp_hi;
        if (q.bit_idx == `SADC_LSB_IDX) begin
          d.state = SADC_PUSH;
        end else begin
          d.trial[q.bit_idx - `SADC_IDX_ONE] = 1'b1;
          d.bit_idx                          = q.bit_idx - `SADC_IDX_ONE;
        end
      end
      SADC_PUSH: begin
        // Wait here while the FIFO is full so that no result is lost.
        if (fifo_in_ready) begin
          d.state = SADC_IDLE;
        end
      end
      default: begin
        d.state = SADC_IDLE;
      end
    endcase

    // A completed result becomes the held value and the new shift-out start.
    if (fifo_pop) begin
      d.held = fifo_out_data;
      d.shf  = fifo_out_data;
      d.eoc  = 1'b1;
      // With select still low the counters restart, so the new MSB opens the next transfer.
      if (active) begin
        d.rise_cnt = `SADC_CNT_ZERO;
        d.fall_cnt = `SADC_CNT_ZERO;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      q          <= '0;
      // The select path resets to its idle high level so no false select edge follows reset.
      q.cs_sy    <= `SADC_RST_SYNC;
      q.cs_f     <= 1'b1;
      q.cs_prev  <= 1'b1;
      q.held     <= `SADC_RST_RESULT;
      q.chan     <= `SADC_RST_CHAN;
      q.chan_sel <= `SADC_RST_SEL;
      q.eoc      <= 1'b1;
      q.state    <= SADC_IDLE;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Every output is a register bit, so the pins carry no logic glitches.
  assign dout_o    = q.shf[`SADC_RES_W-1];
  assign dout_oe   = q.dout_oe;
  assign eoc       = q.eoc;
  assign chan_sel  = q.chan_sel;
  assign sample_en = q.sample;
  assign dac_code  = q.trial;

endmodule // sadc_ctrl

// ==== test/sadc_chk.sv ====
// Purpose: Concurrent checks on the ports of the converter control top.
// Assumes: Link pins are sampled inside, so bounds allow for the synchroniser delay.
// Notes:   Bound into sadc_ctrl after the module.
`timescale 1ns/1ps
`include "sadc_defs.svh"

module sadc_chk (
  // Clock and reset
  input wire logic                    clock,
  input wire logic                    rst,
  // Link pins
  input wire logic                    cs_n,
  input wire logic                    dout_o,
  input wire logic                    dout_oe,
  input wire logic                    eoc,
  // Front end
  input wire logic [`SADC_NUM_CH-1:0] chan_sel,
  input wire logic                    sample_en
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // ------------
  // Checks
  // ------------
  a_idle_floats: assert property (cs_n [*8] |-> !dout_oe) else $error("pin driven while idle");
  a_select_drives: assert property (!cs_n [*8] |-> dout_oe) else $error("pin not driven");
  a_chan_onehot: assert property ($onehot0(chan_sel)) else $error("selector not one-hot");
  a_tenth_zero: assert property ($fell(eoc) |-> !dout_o && $fell(sample_en)) else $error("tenth fall");
  a_done_returns: assert property ($fell(eoc) |-> ##[1:200] eoc) else $error("done never rose");
  a_done_in_frame: assert property ($fell(eoc) |-> !cs_n) else $error("done fell outside a frame");
  a_sample_idle: assert property (sample_en |-> eoc) else $error("sampling while converting");
  a_addr_locked: assert property (sample_en [*2] |-> $stable(chan_sel)) else $error("address moved");
  a_deselect_quiet: assert property (cs_n [*8] |-> $stable(chan_sel)) else $error("input while idle");

  c_done_rise: cover property ($rose(eoc));
  c_sample_start: cover property ($rose(sample_en));
  c_pin_enable: cover property (!dout_oe ##1 dout_oe);
endmodule // sadc_chk

bind sadc_ctrl sadc_chk chk (.clock(clock), .rst(rst), .cs_n(cs_n), .dout_o(dout_o), .dout_oe(dout_oe),
                             .eoc(eoc), .chan_sel(chan_sel), .sample_en(sample_en));

// ==== test/sadc_host.sv ====
// Purpose: Host serial port that frames transfers towards the converter.
// Assumes: Pins change 1 ns after a clock edge; the shift clock period is 32 ns.
// Notes:   Samples are taken just before each shift clock fall and once after the last.
`timescale 1ns/1ps

module sadc_host (
  // Clock
  input wire logic clock,
  // Towards the converter
  output logic     cs_n,
  output logic     shift_clk,
  output logic     addr_in,
  // From the converter
  input wire logic dout_pin,
  input wire logic eoc
);
  logic got[$];
  logic eo[$];

  initial begin
    cs_n = 1'b1;
    shift_clk = 1'b0;
    addr_in = 1'b0;
  end

  // ------------
  // Transfers
  // ------------
  task automatic xfer(input logic [3:0] a, input int n);
    got.delete();
    eo.delete();
    @(posedge clock);
    #1;
    cs_n = 1'b0;
    #16;
    for (int k = 1; k <= n; k++) begin
      // Past the address the line keeps toggling so a late capture shows.
      addr_in = (k <= 4) ? a[4-k] : ~addr_in;
      #16;
      shift_clk = 1'b1;
      #16;
      got.push_back(dout_pin);
      eo.push_back(eoc);
      shift_clk = 1'b0;
    end
    #32;
    got.push_back(dout_pin);
    eo.push_back(eoc);
    cs_n = 1'b1;
    // Select stays high long enough for the converter's pin filter to see it.
    #32;
  endtask
endmodule // sadc_host

// ==== test/sadc_ctrl_tb_top.sv ====
// Purpose: Self-checking bench for the converter control top and its result FIFO.
// Assumes: The bench models the analog inputs and the comparator.
// Notes:   An unused address code selects nothing and converts to zero.
`timescale 1ns/1ps
`include "sadc_defs.svh"

module sadc_ctrl_tb_top;
  logic                    clock;
  logic                    rst;
  logic                    cs_n;
  logic                    shift_clk;
  logic                    addr_in;
  logic                    dout_o;
  logic                    dout_oe;
  logic                    eoc;
  logic                    sample_en;
  logic                    cmp_hi;
  logic [`SADC_NUM_CH-1:0] chan_sel;
  logic [`SADC_RES_W-1:0]  dac_code;
  logic [`SADC_RES_W-1:0]  vin;
  logic [`SADC_RES_W-1:0]  prev;
  logic [`SADC_RES_W-1:0]  ain [`SADC_NUM_CH];
  logic [3:0]              a;
  wire                     dout_pin;
  int                      n;
  int                      w;
  int                      n_mismatch = 0;
  int                      comparisons = 0;

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  assign dout_pin = dout_oe ? dout_o : 1'bz;

  always_comb begin
    vin = `SADC_RST_RESULT;
    for (int i = 0; i < `SADC_NUM_CH; i++) begin
      if (chan_sel[i]) begin
        vin = ain[i];
      end
    end
  end
  assign cmp_hi = (vin >= dac_code);

  sadc_ctrl dut (.clock(clock), .rst(rst), .cs_n(cs_n), .shift_clk(shift_clk), .addr_in(addr_in),
                 .dout_o(dout_o), .dout_oe(dout_oe), .eoc(eoc), .chan_sel(chan_sel),
                 .sample_en(sample_en), .dac_code(dac_code), .cmp_hi(cmp_hi));
  sadc_host host (.clock(clock), .cs_n(cs_n), .shift_clk(shift_clk), .addr_in(addr_in),
                  .dout_pin(dout_pin), .eoc(eoc));

  // ------------
  // Tests
  // ------------
  task automatic check_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    void'($urandom(4));
    rst = 1'b1;
    prev = `SADC_RST_RESULT;
    repeat (2) @(posedge clock);
    #1;
    rst = 1'b0;
    repeat (8) @(posedge clock);
    // Every address code, then random ones; lengths 10 to 12 keep the frame ahead of the conversion.
    // Transfer 24 ends in a reset, so transfer 25 must read the cleared result.
    for (int t = 0; t < 26; t++) begin
      a = (t < 16) ? 4'(t) : 4'($urandom_range(15, 0));
      n = (t == 0) ? 10 : int'($urandom_range(12, 10));
      foreach (ain[i]) ain[i] = 10'($urandom_range(1023, 0));
      host.xfer(a, n);
      for (int i = 0; i <= n; i++) begin
        if (i < 10) check_bit(host.got[i], prev[9-i], "result bit");
        else if (host.eo[i] === 1'b0) check_bit(host.got[i], 1'b0, "pad bit");
      end
      check_bit(host.eo[10], 1'b0, "done low");
      check_word(16'(chan_sel), (a < 14) ? 16'(16'h0001 << a) : 16'h0000, "selector");
      if (t == 24) begin
        // A reset mid-run must clear the FIFO, the held result and the pins.
        rst = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        rst = 1'b0;
        check_bit(eoc, 1'b1, "done after reset");
        check_bit(dout_oe, 1'b0, "pin after reset");
        check_word(16'(chan_sel), 16'h0000, "selector after reset");
        prev = `SADC_RST_RESULT;
      end else begin
        w = 0;
        while (eoc !== 1'b1 && w < 200) begin
          @(posedge clock);
          #1;
          w++;
        end
        check_bit(eoc, 1'b1, "done high");
        prev = (a < 14) ? ain[a] : `SADC_RST_RESULT;
      end
      $display("test transfer %0d done", t);
    end
    report_and_stop();
  end
endmodule // sadc_ctrl_tb_top
